// ---- inc/sce_pkg.sv ----
// Types shared by the serial command executor.
// Assumes the constants header is included by each design file that uses its macros.
package sce_pkg;
    typedef enum logic [3:0] {
        SCE_KEY, SCE_ARG, SCE_EXEC, SCE_REPLY, SCE_SKIP,
        SCE_CHDR, SCE_CCHK, SCE_CSTR, SCE_CSEND, SCE_CDRAIN
    } sce_state_t;
endpackage

// ---- inc/sce_regs.svh ----
// Constants of the serial command executor: characters, keywords, defaults.
// Assumes includers take these as plain text macros.
`ifndef SCE_REGS_SVH
`define SCE_REGS_SVH
`define SCE_CH_CR 8'h0D
`define SCE_CH_LF 8'h0A
`define SCE_CH_SP 8'h20
`define SCE_CH_COMMA 8'h2C
`define SCE_CH_HASH 8'h23
`define SCE_CH_ZERO 8'h30
`define SCE_KW_CMD 32'h00636D64
`define SCE_KW_CONF 32'h636F6E66
`define SCE_KW_ECHO 32'h6563686F
`define SCE_KW_EOS 32'h00656F73
`define SCE_CNT_MIN 33'h000000001
`define SCE_CNT_MAX 33'h0FFFFFFFF
`define SCE_PP_OPT 33'h000000000
`define SCE_BOOL_MAX 33'h000000001
`define SCE_CHAR_MAX 33'h0000000FF
`define SCE_PP_LOCAL_RST 1'b0
`define SCE_ECHO_RST 1'b0
`define SCE_EOS_MODE_RST 1'b0
`define SCE_EOS_CHAR_RST 8'h00
`define SCE_RBUF_LEN 12
`define SCE_RIDX_W 4
`endif

// ---- rtl/sce_cmd_exec.sv ----
// Command interpreter: raw bus commands, conf, echo and eos settings.
// Assumes serial bytes and bus status come from logic on mclk.
`include "sce_regs.svh"
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Raw command count is decimal after '#', from 1 to 4294967295.
// - Without count, raw string ends at first CR or LF.
// - Header ended by CR alone: leading LF of string is discarded.
// - Standby controller-in-charge takes active control, stays active after.
// - Transfer ends on done, not in charge, timeout, no listener, serial error.
// - Count of bytes actually sent is stored at transfer end.
// - After an early stop, the rest of the string is read and dropped.
// - Each raw byte goes out unchanged as an interface message.
// - Option 0 picks remote (0) or local (1) poll config; default 0.
// - Local poll config selected: remote poll configurations are ignored.
// - Option named without value returns its present setting.
// - Settings hold until changed, online command, or power loss.
// - Echo 1 sends every received character back; echo 0 sends none.
// - Enabling echo does not echo the enabling command itself.
// - Letters R, X, B, D set modes; omitted letters are disabled.
// - Read ends on match, seven bits unless full compare.
// - Write raises EOI with matching byte, seven or eight bits.
// - Terminator command with only the full-compare letter is rejected.
// - The terminator byte is never inserted into written data.
// - Terminator command without arguments returns present settings.
// - Controller operation while not in charge records not-in-charge.
module sce_cmd_exec
    import sce_pkg::*;
(
    input wire logic mclk, // 250 MHz clock
    input wire logic srst, // Synchronous reset, high
    input wire logic rx_valid, // Serial byte available
    input wire logic [7:0] rx_data, // Serial byte
    output logic rx_ready, // Serial byte taken
    output logic tx_valid, // Serial byte to send
    output logic [7:0] tx_data, // Serial byte out
    input wire logic tx_ready, // Serial sender takes byte
    input wire logic bus_cic, // Controller-in-charge
    input wire logic bus_standby_req, // Go to standby pulse
    input wire logic bus_ready, // Bus took command byte
    input wire logic io_timeout, // I/O time limit expired
    input wire logic bus_no_listener, // No listener present
    input wire logic serial_err, // Unignored serial error
    input wire logic online_req, // Online command pulse
    output logic cmd_byte_valid, // Command byte offered
    output logic [7:0] cmd_byte, // Command byte to bus
    output logic atn, // Active controller, ATN asserted
    output logic cmd_done, // Raw transfer ended pulse
    output logic [31:0] cmd_sent_count, // Bytes actually sent
    output logic not_in_charge_error, // Error pulse
    output logic timeout_abort_error, // Error pulse
    output logic no_listener_error, // Error pulse
    output logic invalid_argument_error, // Error pulse
    output logic parallel_poll_local, // Local poll config
    output logic echo_enable, // Echo setting
    output logic read_end_on_match, // Read terminator mode
    output logic write_end_on_match, // Write terminator mode
    output logic full_byte_compare, // Eight-bit compare mode
    output logic [7:0] eos_char, // Terminator character
    input wire logic remote_ppc_valid, // Remote poll config seen
    output logic remote_ppc_accept, // Remote poll config taken
    input wire logic [7:0] rd_byte, // Byte read from bus
    output logic rd_end, // Read must end
    input wire logic [7:0] wr_byte, // Byte being written
    output logic wr_eoi // EOI with this byte
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] lc(input logic [7:0] c);
        lc = (c >= 8'h41 && c <= 8'h5A) ? (c | 8'h20) : c;
    endfunction

    function automatic logic is_dig(input logic [7:0] c);
        is_dig = (c >= 8'h30 && c <= 8'h39);
    endfunction

    function automatic logic is_term(input logic [7:0] c);
        is_term = (c == `SCE_CH_CR) || (c == `SCE_CH_LF);
    endfunction

    // Saturates one past the limit so an oversize count stays visible
    function automatic logic [32:0] acc10(input logic [32:0] v,
                                          input logic [7:0] c);
        logic [36:0] t;
        t = {4'h0, v} * 37'd10 + {29'h0, c - `SCE_CH_ZERO};
        acc10 = (t > {4'h0, `SCE_CNT_MAX}) ? `SCE_CNT_MAX + 33'h1 : t[32:0];
    endfunction

    function automatic logic [7:0] ascii_bit(input logic b);
        ascii_bit = `SCE_CH_ZERO | {7'h0, b};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sce_state_t state, next_state;
    logic [31:0] kw, next_kw;
    logic [32:0] num, next_num, num0, next_num0, num1, next_num1;
    logic num_on, next_num_on, bad, next_bad;
    logic [1:0] nums, next_nums;
    logic lr, next_lr, lx, next_lx, lb, next_lb, ld, next_ld;
    logic have_cnt, next_have_cnt, hdr_cr, next_hdr_cr, first, next_first;
    logic [31:0] rem, next_rem, sent, next_sent, next_cmd_sent_count;
    logic [7:0] next_cmd_byte, next_tx_data, next_eos_char;
    logic [7:0] rbuf [0:`SCE_RBUF_LEN-1];
    logic [7:0] next_rbuf [0:`SCE_RBUF_LEN-1];
    logic [`SCE_RIDX_W-1:0] ridx, next_ridx, rlen, next_rlen;
    logic next_tx_valid, next_atn, next_cmd_done;
    logic next_nic, next_abo, next_nol, next_arg;
    logic next_pp, next_echo, next_rd, next_wr, next_bin;
    logic rx_fire, tx_free, clr_tok, finish;
    logic [7:0] c;
    logic [`SCE_RIDX_W-1:0] p;
    logic [7:0] h, t, o;

    assign cmd_byte_valid = (state == SCE_CSEND);
    assign tx_free = !tx_valid || tx_ready;
    assign rx_ready = (state == SCE_KEY || state == SCE_ARG ||
                       state == SCE_SKIP || state == SCE_CHDR ||
                       state == SCE_CSTR || state == SCE_CDRAIN) &&
                      (!echo_enable || tx_free);
    assign rx_fire = rx_valid && rx_ready;
    assign c = lc(rx_data);
    assign remote_ppc_accept = remote_ppc_valid && !parallel_poll_local;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state; next_kw = kw; next_num = num; next_num0 = num0;
        next_num1 = num1; next_num_on = num_on; next_bad = bad;
        next_nums = nums; next_lr = lr; next_lx = lx; next_lb = lb;
        next_ld = ld; next_have_cnt = have_cnt; next_hdr_cr = hdr_cr;
        next_first = first; next_rem = rem; next_sent = sent;
        next_cmd_sent_count = cmd_sent_count; next_cmd_byte = cmd_byte;
        next_eos_char = eos_char; next_rbuf = rbuf; next_ridx = ridx;
        next_rlen = rlen; next_atn = atn; next_cmd_done = 1'b0;
        next_nic = 1'b0; next_abo = 1'b0; next_nol = 1'b0; next_arg = 1'b0;
        next_pp = parallel_poll_local; next_echo = echo_enable;
        next_rd = read_end_on_match; next_wr = write_end_on_match;
        next_bin = full_byte_compare;
        clr_tok = 1'b0; finish = 1'b0; p = '0;
        {h, t, o} = {8'h0, 8'h0, 8'h0};
        next_tx_valid = tx_valid && !tx_ready;
        next_tx_data = tx_data;
        // Setting changes apply after the command, so "echo 1" is silent
        if (rx_fire && echo_enable)
        begin
            next_tx_valid = 1'b1;
            next_tx_data = rx_data;
        end
        case (state)
        SCE_KEY:
            if (rx_fire)
            begin
                if (is_term(c))
                begin
                    if (kw == `SCE_KW_CMD)
                    begin
                        next_hdr_cr = (c == `SCE_CH_CR);
                        next_state = SCE_CCHK;
                    end
                    else if (kw == `SCE_KW_CONF || kw == `SCE_KW_ECHO ||
                             kw == `SCE_KW_EOS)
                        next_state = SCE_EXEC;
                    else
                        clr_tok = 1'b1;
                end
                else if (c == `SCE_CH_HASH && kw == `SCE_KW_CMD)
                begin
                    next_have_cnt = 1'b1;
                    next_state = SCE_CHDR;
                end
                else if (c == `SCE_CH_SP)
                begin
                    if (kw == `SCE_KW_CMD)
                        next_state = SCE_CHDR;
                    else if (kw == `SCE_KW_CONF || kw == `SCE_KW_ECHO ||
                             kw == `SCE_KW_EOS)
                        next_state = SCE_ARG;
                    else if (kw != 32'h0)
                        next_state = SCE_SKIP;
                end
                else
                    next_kw = {kw[23:0], c};
            end
        SCE_ARG:
            if (rx_fire)
            begin
                if (is_dig(c))
                begin
                    next_num = acc10(num, c);
                    next_num_on = 1'b1;
                end
                else if (c == 8'h72)
                    next_lr = 1'b1;
                else if (c == 8'h78)
                    next_lx = 1'b1;
                else if (c == 8'h62)
                    next_lb = 1'b1;
                else if (c == 8'h64)
                    next_ld = 1'b1;
                else if (!is_term(c) && c != `SCE_CH_SP &&
                         c != `SCE_CH_COMMA)
                    next_bad = 1'b1;
                if (num_on && !is_dig(c))
                begin
                    if (nums == 2'd0)
                        next_num0 = num;
                    else if (nums == 2'd1)
                        next_num1 = num;
                    if (nums != 2'd3)
                        next_nums = nums + 2'd1;
                    next_num = 33'h0;
                    next_num_on = 1'b0;
                end
                if (is_term(c))
                    next_state = SCE_EXEC;
            end
        SCE_EXEC:
        begin
            next_state = SCE_KEY;
            clr_tok = 1'b1;
            next_rlen = 4'd3;
            next_ridx = '0;
            next_rbuf[1] = `SCE_CH_CR;
            next_rbuf[2] = `SCE_CH_LF;
            if (bad)
                next_arg = 1'b1;
            else if (kw == `SCE_KW_CONF)
            begin
                if (nums == 2'd0 || num0 != `SCE_PP_OPT)
                    next_arg = 1'b1;
                else if (nums == 2'd1)
                begin
                    next_rbuf[0] = ascii_bit(parallel_poll_local);
                    next_state = SCE_REPLY;
                end
                else if (num1 > `SCE_BOOL_MAX)
                    next_arg = 1'b1;
                else
                    next_pp = num1[0];
            end
            else if (kw == `SCE_KW_ECHO)
            begin
                if (nums == 2'd0)
                begin
                    next_rbuf[0] = ascii_bit(echo_enable);
                    next_state = SCE_REPLY;
                end
                else if (num0 > `SCE_BOOL_MAX)
                    next_arg = 1'b1;
                else
                    next_echo = num0[0];
            end
            else if (!lr && !lx && !lb && !ld && nums == 2'd0)
            begin
                // Letters with commas, then the code in decimal
                if (read_end_on_match)
                begin
                    next_rbuf[p] = 8'h52; next_rbuf[p+4'd1] = `SCE_CH_COMMA;
                    p = p + 4'd2;
                end
                if (write_end_on_match)
                begin
                    next_rbuf[p] = 8'h58; next_rbuf[p+4'd1] = `SCE_CH_COMMA;
                    p = p + 4'd2;
                end
                if (full_byte_compare)
                begin
                    next_rbuf[p] = 8'h42; next_rbuf[p+4'd1] = `SCE_CH_COMMA;
                    p = p + 4'd2;
                end
                h = eos_char / 8'd100;
                t = (eos_char / 8'd10) % 8'd10;
                o = eos_char % 8'd10;
                if (h != 8'h0)
                begin
                    next_rbuf[p] = `SCE_CH_ZERO + h; p = p + 4'd1;
                end
                if (h != 8'h0 || t != 8'h0)
                begin
                    next_rbuf[p] = `SCE_CH_ZERO + t; p = p + 4'd1;
                end
                next_rbuf[p] = `SCE_CH_ZERO + o;
                next_rbuf[p+4'd1] = `SCE_CH_CR;
                next_rbuf[p+4'd2] = `SCE_CH_LF;
                next_rlen = p + 4'd3;
                next_state = SCE_REPLY;
            end
            else if (lb && !lr && !lx && !ld)
                next_arg = 1'b1;
            else if (nums != 2'd0 && num0 > `SCE_CHAR_MAX)
                next_arg = 1'b1;
            else
            begin
                next_rd = lr && !ld;
                next_wr = lx && !ld;
                next_bin = lb && !ld;
                if (nums != 2'd0)
                    next_eos_char = num0[7:0];
            end
        end
        SCE_REPLY:
            if (tx_free)
            begin
                next_tx_valid = 1'b1;
                next_tx_data = rbuf[ridx];
                next_ridx = ridx + 4'd1;
                if (ridx == rlen - 4'd1)
                    next_state = SCE_KEY;
            end
        SCE_SKIP:
            if (rx_fire && is_term(c))
            begin
                next_state = SCE_KEY;
                clr_tok = 1'b1;
            end
        SCE_CHDR:
            if (rx_fire)
            begin
                if (is_term(c))
                begin
                    next_hdr_cr = (c == `SCE_CH_CR);
                    next_state = SCE_CCHK;
                end
                else if (c == `SCE_CH_HASH)
                    next_have_cnt = 1'b1;
                else if (is_dig(c) && have_cnt)
                    next_num = acc10(num, c);
                else if (c != `SCE_CH_SP)
                    next_bad = 1'b1;
            end
        SCE_CCHK:
        begin
            next_sent = 32'h0;
            next_rem = num[31:0];
            next_first = 1'b1;
            next_state = SCE_CSTR;
            if (bad || (have_cnt && (num < `SCE_CNT_MIN ||
                                     num > `SCE_CNT_MAX)))
            begin
                next_arg = 1'b1;
                next_have_cnt = 1'b0;
                next_state = SCE_CDRAIN;
            end
            else if (!bus_cic)
            begin
                next_nic = 1'b1;
                next_state = SCE_CDRAIN;
            end
        end
        SCE_CSTR, SCE_CDRAIN:
            if (rx_fire)
            begin
                next_first = 1'b0;
                if (first && hdr_cr && rx_data == `SCE_CH_LF)
                    next_first = 1'b0;
                else if (!have_cnt && is_term(rx_data))
                    finish = 1'b1;
                else if (state == SCE_CDRAIN)
                begin
                    next_rem = rem - 32'h1;
                    finish = have_cnt && rem == 32'h1;
                end
                else
                begin
                    next_cmd_byte = rx_data;
                    next_state = SCE_CSEND;
                    next_atn = 1'b1;
                end
            end
        SCE_CSEND:
            // Abort wins over bus_ready; the offer drops at the next edge and the byte is not counted
            if (!bus_cic || io_timeout || bus_no_listener || serial_err)
            begin
                next_nic = !bus_cic;
                next_abo = bus_cic && io_timeout;
                next_nol = bus_cic && !io_timeout && bus_no_listener;
                next_rem = rem - 32'h1;
                next_state = SCE_CDRAIN;
                finish = have_cnt && rem == 32'h1;
            end
            else if (bus_ready)
            begin
                next_sent = sent + 32'h1;
                next_rem = rem - 32'h1;
                next_state = SCE_CSTR;
                finish = have_cnt && rem == 32'h1;
            end
        default:
            next_state = SCE_KEY;
        endcase
        if (finish)
        begin
            next_state = SCE_KEY;
            clr_tok = 1'b1;
            next_cmd_done = 1'b1;
            next_cmd_sent_count = next_sent;
        end
        if (clr_tok)
        begin
            next_kw = 32'h0; next_num = 33'h0; next_num_on = 1'b0;
            next_nums = 2'd0; next_bad = 1'b0; next_have_cnt = 1'b0;
            {next_lr, next_lx, next_lb, next_ld} = 4'h0;
        end
        if (!bus_cic || bus_standby_req)
            next_atn = 1'b0;
        if (online_req)
        begin
            next_pp = `SCE_PP_LOCAL_RST;
            next_echo = `SCE_ECHO_RST;
            {next_rd, next_wr, next_bin} = {3{`SCE_EOS_MODE_RST}};
            next_eos_char = `SCE_EOS_CHAR_RST;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state <= SCE_KEY; kw <= 32'h0; num <= 33'h0; num0 <= 33'h0;
            num1 <= 33'h0; num_on <= 1'b0; bad <= 1'b0; nums <= 2'd0;
            {lr, lx, lb, ld} <= 4'h0; have_cnt <= 1'b0; hdr_cr <= 1'b0;
            first <= 1'b0; rem <= 32'h0; sent <= 32'h0;
            cmd_sent_count <= 32'h0; cmd_byte <= 8'h00;
            rbuf <= '{default: 8'h00}; ridx <= '0; rlen <= '0;
            tx_valid <= 1'b0; tx_data <= 8'h00; atn <= 1'b0;
            cmd_done <= 1'b0; not_in_charge_error <= 1'b0;
            timeout_abort_error <= 1'b0; no_listener_error <= 1'b0;
            invalid_argument_error <= 1'b0;
            parallel_poll_local <= `SCE_PP_LOCAL_RST;
            echo_enable <= `SCE_ECHO_RST;
            read_end_on_match <= `SCE_EOS_MODE_RST;
            write_end_on_match <= `SCE_EOS_MODE_RST;
            full_byte_compare <= `SCE_EOS_MODE_RST;
            eos_char <= `SCE_EOS_CHAR_RST;
        end
        else
        begin
            state <= next_state; kw <= next_kw; num <= next_num;
            num0 <= next_num0; num1 <= next_num1; num_on <= next_num_on;
            bad <= next_bad; nums <= next_nums; lr <= next_lr;
            lx <= next_lx; lb <= next_lb; ld <= next_ld;
            have_cnt <= next_have_cnt; hdr_cr <= next_hdr_cr;
            first <= next_first; rem <= next_rem; sent <= next_sent;
            cmd_sent_count <= next_cmd_sent_count; cmd_byte <= next_cmd_byte;
            rbuf <= next_rbuf; ridx <= next_ridx; rlen <= next_rlen;
            tx_valid <= next_tx_valid; tx_data <= next_tx_data;
            atn <= next_atn; cmd_done <= next_cmd_done;
            not_in_charge_error <= next_nic; timeout_abort_error <= next_abo;
            no_listener_error <= next_nol; invalid_argument_error <= next_arg;
            parallel_poll_local <= next_pp; echo_enable <= next_echo;
            read_end_on_match <= next_rd; write_end_on_match <= next_wr;
            full_byte_compare <= next_bin; eos_char <= next_eos_char;
        end
    end

    sce_eos_match u_match (
        .eos_char(eos_char),
        .rd_en(read_end_on_match),
        .wr_en(write_end_on_match),
        .full_cmp(full_byte_compare),
        .rd_byte(rd_byte),
        .wr_byte(wr_byte),
        .rd_end(rd_end),
        .wr_eoi(wr_eoi)
    );
endmodule
`default_nettype wire

// ---- rtl/sce_eos_match.sv ----
// End-of-string comparator for bus reads and writes.
// Assumes mode bits and character come from registered settings.
`timescale 1ns/1ns
`default_nettype none
module sce_eos_match
    import sce_pkg::*;
(
    input wire logic [7:0] eos_char, // Terminator character
    input wire logic rd_en, // Read end on match
    input wire logic wr_en, // Write end on match
    input wire logic full_cmp, // Eight-bit compare
    input wire logic [7:0] rd_byte, // Byte read from bus
    input wire logic [7:0] wr_byte, // Byte about to be written
    output logic rd_end, // Read must end here
    output logic wr_eoi // Raise EOI with this byte
);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b,
                                 input logic full);
        hit = full ? (a == b) : (a[6:0] == b[6:0]);
    endfunction

    // Only flags the byte; the byte stream itself is never extended
    assign rd_end = rd_en && hit(rd_byte, eos_char, full_cmp);
    assign wr_eoi = wr_en && hit(wr_byte, eos_char, full_cmp);
endmodule
`default_nettype wire

// ---- testbench/sce_cmd_exec_properties.sv ----
// Assertions on the command executor ports, bound to its top module.
// Assumes one clock, mclk, with synchronous active-high srst.
`timescale 1ns/1ns
`default_nettype none
module sce_cmd_exec_properties (
    input wire logic mclk, srst, bus_cic, online_req, io_timeout, bus_ready,
    input wire logic remote_ppc_valid, remote_ppc_accept, rd_end, wr_eoi,
    input wire logic [7:0] rd_byte, wr_byte, eos_char,
    input wire logic read_end_on_match, write_end_on_match, full_byte_compare,
    input wire logic parallel_poll_local, echo_enable, cmd_byte_valid, atn,
    input wire logic cmd_done, timeout_abort_error
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Seven-bit match unless full compare is on
    wire logic rd_hit = full_byte_compare ? rd_byte == eos_char
        : rd_byte[6:0] == eos_char[6:0];
    wire logic wr_hit = full_byte_compare ? wr_byte == eos_char
        : wr_byte[6:0] == eos_char[6:0];
    sequence s_stuck;
        cmd_byte_valid && bus_cic && io_timeout && !bus_ready;
    endsequence
    AST_RD_END: assert property (rd_end == (read_end_on_match && rd_hit))
        else $error("read end mismatch");
    AST_WR_EOI: assert property (wr_eoi == (write_end_on_match && wr_hit))
        else $error("write eoi mismatch");
    AST_PPC: assert property (remote_ppc_accept ==
        (remote_ppc_valid && !parallel_poll_local)) else $error("ppc taken");
    AST_ONLINE: assert property (online_req |-> ##[1:2] !(echo_enable ||
        parallel_poll_local || read_end_on_match || write_end_on_match ||
        full_byte_compare)) else $error("online kept settings");
    AST_ATN_DROP: assert property (!bus_cic |=> !atn)
        else $error("atn without charge");
    AST_ATN_SEND: assert property (cmd_byte_valid |-> atn)
        else $error("command byte without atn");
    AST_TMO: assert property (s_stuck |-> ##[1:2] timeout_abort_error)
        else $error("timeout not flagged");
    AST_DONE: assert property (cmd_done |=> !cmd_done)
        else $error("done longer than a pulse");
endmodule
bind sce_cmd_exec sce_cmd_exec_properties sce_cmd_exec_properties_i (.*);
`default_nettype wire

// ---- testbench/sce_host_model.sv ----
// Serial host: offers queued line bytes, stalls the echo path at random.
// Assumes the bench fills q with whole lines and decimal arguments.
`timescale 1ns/1ns
`default_nettype none
module sce_host_model (
    input wire logic mclk, // Clock
    input wire logic srst, // Reset
    output logic rx_valid, // Byte offered
    output logic [7:0] rx_data, // Byte
    input wire logic rx_ready, // Byte taken
    output logic tx_ready // Host accepts reply byte
);
    byte unsigned q[$];
    initial {rx_valid, rx_data, tx_ready} = 10'h0FF;
    always @(posedge mclk)
    begin
        tx_ready <= $urandom_range(3) != 0;
        // Idle data flips so a stale byte never looks valid
        if (srst)
            rx_valid <= 1'b0;
        else if (!rx_valid || rx_ready)
        begin
            rx_valid <= q.size() != 0;
            rx_data <= q.size() != 0 ? q.pop_front() : ~rx_data;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tb_sce_cmd_exec.sv ----
// Self-checking bench for the command executor with a serial host model.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module tb_sce_cmd_exec;
    logic mclk = 0, srst = 1, bus_cic = 1, bus_ready = 0, io_timeout = 0;
    logic online_req = 0, remote_ppc_valid = 0, stall = 0;
    logic bus_standby_req = 0, bus_no_listener = 0, serial_err = 0;
    logic [7:0] rd_byte = 8'h00, wr_byte = 8'h00, rx_data, tx_data, cmd_byte;
    logic [7:0] eos_char;
    logic [31:0] cmd_sent_count;
    logic rx_valid, rx_ready, tx_valid, tx_ready, cmd_byte_valid, atn, cmd_done;
    logic not_in_charge_error, timeout_abort_error, no_listener_error;
    logic invalid_argument_error, parallel_poll_local, echo_enable, rd_end;
    logic read_end_on_match, write_end_on_match, full_byte_compare, wr_eoi;
    logic remote_ppc_accept;
    logic [8:0] expq[$];
    int error_cnt = 0, checks = 0, nic = 0, tmo = 0, arg = 0, nol = 0, steps = 0;
    sce_cmd_exec sce_cmd_exec_i (.*);
    sce_host_model sce_host_model_i (.*);
    always #2 mclk = ~mclk;
    task automatic chk(input string n, input logic [31:0] s, e);
        checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Line out through the host; e is what must appear, c marks bus bytes
    task automatic send(input string s, input string e = "", input bit c = 0);
        int k;
        foreach (s[i]) sce_host_model_i.q.push_back(s[i]);
        foreach (e[i]) expq.push_back({c, e[i]});
        for (k = 0; k < 4000 && !(k > 20 && !rx_valid && expq.size() == 0
            && sce_host_model_i.q.size() == 0); k++) @(posedge mclk);
        if (k == 4000)
        begin
            error_cnt++;
            stop_test();
        end
        steps++;
        $display("test %0d done", steps);
    endtask
    always @(posedge mclk)
    begin
        bus_ready <= !stall && $urandom_range(1);
        {rd_byte, wr_byte, remote_ppc_valid} <= 17'($urandom);
        if (!srst)
        begin
            {nic, tmo, arg, nol} = {nic + not_in_charge_error,
                tmo + timeout_abort_error, arg + invalid_argument_error,
                nol + no_listener_error};
            if (tx_valid && tx_ready)
                chk("tx", {1'b0, tx_data}, expq.size() ? expq.pop_front() : 9'h1FF);
            if (cmd_byte_valid && bus_ready)
                chk("cmd", {1'b1, cmd_byte}, expq.size() ? expq.pop_front() : 9'h1FF);
        end
    end
    initial
    begin
        void'($urandom(32'hDA7BCA87));
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        send("conf 0 1\n");
        chk("pp", parallel_poll_local, 1);
        send("CONF 0\n", "1\r\n");
        send("eos r,x,b,10\nEos\n", "R,X,B,10\r\n");
        send("eos b,10\n");
        chk("arg", arg, 1);
        chk("mode", {read_end_on_match, write_end_on_match, full_byte_compare, eos_char}, 11'h70A);
        send("eos x,13\neos\n", "X,13\r\n");
        send("cmd #2\n_\r\n", "_\r", 1);
        chk("count", cmd_sent_count, 2);
        send("cmd #1\r\n@", "@", 1);
        send("cmd\n?\n", "?", 1);
        bus_cic <= 1'b0;
        send("cmd\n_\n");
        chk("nic", nic, 1);
        bus_cic <= 1'b1;
        {stall, io_timeout} <= 2'b11;
        send("cmd\n_?\n");
        chk("tmo", {tmo[15:0], cmd_sent_count[15:0]}, 32'h00010000);
        {io_timeout, bus_no_listener} <= 2'b01;
        send("cmd\n_\n");
        chk("nol", nol, 1);
        {stall, bus_no_listener} <= 2'b00;
        send("echo 1\necho\n", "echo\n1\r\n");
        online_req <= 1'b1;
        @(posedge mclk) online_req <= 1'b0;
        send("echo\n", "0\r\n");
        chk("pp", parallel_poll_local, 0);
        stop_test();
    end
endmodule
`default_nettype wire
